// ---- aic_pkg.sv ----
// Package with register map, field layout, codes and timing constants for the converter control
// ==========================================================================
package aic_pkg;
	// ======================================================================
	// Register map (byte registers)
	localparam logic [2:0] AIC_OFF_CTRL = 3'h0;
	localparam logic [2:0] AIC_OFF_CFG = 3'h1;
	localparam logic [2:0] AIC_OFF_BG = 3'h2;
	localparam logic [2:0] AIC_OFF_RES_H = 3'h3;
	localparam logic [2:0] AIC_OFF_RES_L = 3'h4;
	localparam logic [2:0] AIC_OFF_IRQ = 3'h5;
	localparam logic [7:0] AIC_RST_BYTE = 8'h00;
	// ======================================================================
	// Field positions
	localparam int AIC_BIT_START = 7;
	localparam int AIC_BIT_BUSY = 6;
	localparam int AIC_BIT_EN = 5;
	localparam int AIC_BIT_FMT = 4;
	localparam int AIC_BIT_IRQ_EN = 1;
	localparam int AIC_BIT_IRQ_FLAG = 0;
	localparam int AIC_PINS = 3;
	localparam logic [3:0] AIC_CH_LAST = 4'h2;
	// ======================================================================
	// Timing
	localparam int AIC_SAMPLE_CYC = 4;
	localparam int AIC_CONV_CYC = 10;
	localparam logic [3:0] AIC_TOTAL_CYC = 4'(AIC_SAMPLE_CYC + AIC_CONV_CYC);
	localparam int AIC_SYS_PERIOD_PS = 5000;

	typedef enum logic [2:0] {
		AIC_SRC_EXT0 = 3'b000,
		AIC_SRC_BG = 3'b001,
		AIC_SRC_OP0 = 3'b010,
		AIC_SRC_OP1 = 3'b011,
		AIC_SRC_GND = 3'b100,
		AIC_SRC_EXT5 = 3'b101,
		AIC_SRC_EXT6 = 3'b110,
		AIC_SRC_EXT7 = 3'b111
	} aic_src_e;

	typedef enum logic [1:0] {
		AIC_ST_IDLE = 2'b00,
		AIC_ST_SAMPLE = 2'b01,
		AIC_ST_CONV = 2'b10
	} aic_state_e;

	typedef struct packed {
		logic [2:0] input_source_select;
		logic [1:0] reference_select;
		logic [2:0] conv_clock_divider_select;
	} aic_cfg_s;

	// Analog routing controls toward the converter core
	typedef struct packed {
		logic sel_ext;
		logic sel_bandgap;
		logic sel_opamp0;
		logic sel_opamp1;
		logic sel_ground;
		logic [2:0] ext_pin_on;
		logic ref_supply;
	} aic_route_s;

	function automatic logic aic_is_ext(input logic [2:0] src);
		return (src == AIC_SRC_EXT0) || (src == AIC_SRC_EXT5) || src[2:1] == 2'b11;
	endfunction : aic_is_ext
endpackage : aic_pkg

// ---- aic_clkdiv.sv ----
// Converter clock tick generator: system clock divided by a power of two
`timescale 1ns/1ps
module aic_clkdiv
	import aic_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [2:0] i_div_sel,
	output logic o_tick
);
	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic [6:0] limit;
	logic tick_nxt;

	always_comb begin
		limit = 7'((8'h01 << i_div_sel) - 8'h01);
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!i_run) begin
			cnt_nxt = 7'h00;
		end else if (cnt_r >= limit) begin
			cnt_nxt = 7'h00;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 7'h01;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt_r <= 7'h00;
			o_tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			o_tick <= tick_nxt;
		end
	end

	chk_tick_spacing: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_run && i_div_sel == 3'h1 && $stable(i_div_sel) && o_tick) |=> !o_tick)
		else $error("tick came on consecutive cycles at divide by two");
endmodule : aic_clkdiv

// ---- aic_route.sv ----
// Analog input, reference and bandgap routing decode
`timescale 1ns/1ps
module aic_route
	import aic_pkg::*;
(
	input wire logic [2:0] i_src,
	input wire logic [3:0] i_chan,
	input wire logic [1:0] i_ref,
	output aic_route_s o_route
);
	always_comb begin
		o_route = '0;
		o_route.sel_ext = aic_is_ext(i_src);
		o_route.sel_bandgap = (i_src == AIC_SRC_BG);
		o_route.sel_opamp0 = (i_src == AIC_SRC_OP0);
		o_route.sel_opamp1 = (i_src == AIC_SRC_OP1);
		o_route.sel_ground = (i_src == AIC_SRC_GND);
		// Channel codes past the last pin switch every pin off (floating input)
		for (int i = 0; i < AIC_PINS; i++) begin
			o_route.ext_pin_on[i] = (i_chan == 4'(i));
		end
		o_route.ref_supply = (i_ref == 2'b01);
	end
endmodule : aic_route

// ---- aic_top.sv ----
// Converter control: registers, start sequencing, busy flag, result and routing
`timescale 1ns/1ps
module aic_top
	import aic_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Converter core
	input wire logic [9:0] i_core_result,
	output logic o_core_power,
	output logic o_core_sample,
	output logic o_core_convert,
	output logic o_core_clk_tick,
	output aic_route_s o_route,
	output logic o_bandgap_enable,
	// Pin function selection from outside: 1 means pin is analog input
	input wire logic [AIC_PINS-1:0] i_pin_analog,
	output logic [AIC_PINS-1:0] o_pin_digital_en,
	output logic [AIC_PINS-1:0] o_pin_pullup_allow,
	output logic [AIC_PINS-1:0] o_pin_dir_override,
	// Interrupt request to the interrupt controller
	output logic o_irq
);
	// ======================================================================
	// Register state
	logic start_r, start_nxt;
	logic en_r, en_nxt;
	logic fmt_r, fmt_nxt;
	logic [3:0] chan_r, chan_nxt;
	aic_cfg_s cfg_r, cfg_nxt;
	logic bg_en_r, bg_en_nxt;
	logic irq_en_r, irq_en_nxt;
	logic irq_flag_r, irq_flag_nxt;
	logic [9:0] result_r, result_nxt;
	logic [7:0] rdata_nxt;
	logic done;

	always_comb begin
		start_nxt = start_r;
		en_nxt = en_r;
		fmt_nxt = fmt_r;
		chan_nxt = chan_r;
		cfg_nxt = cfg_r;
		bg_en_nxt = bg_en_r;
		irq_en_nxt = irq_en_r;
		irq_flag_nxt = irq_flag_r;
		result_nxt = result_r;
		if (i_wr) begin
			unique case (i_addr)
				AIC_OFF_CTRL: begin
					start_nxt = i_wdata[AIC_BIT_START];
					en_nxt = i_wdata[AIC_BIT_EN];
					fmt_nxt = i_wdata[AIC_BIT_FMT];
					chan_nxt = i_wdata[3:0];
				end
				AIC_OFF_CFG: begin
					cfg_nxt = i_wdata;
				end
				AIC_OFF_BG: begin
					bg_en_nxt = i_wdata[0];
				end
				AIC_OFF_IRQ: begin
					irq_en_nxt = i_wdata[AIC_BIT_IRQ_EN];
					if (i_wdata[AIC_BIT_IRQ_FLAG]) begin
						irq_flag_nxt = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Set wins over a same-cycle clear
		if (done) begin
			irq_flag_nxt = 1'b1;
			// Result only updates while enabled
			if (en_r) begin
				result_nxt = i_core_result;
			end
		end
	end

	// ======================================================================
	// Start sequencing and conversion timing
	aic_state_e state_r, state_nxt;
	logic [3:0] cyc_r, cyc_nxt;
	logic busy_r, busy_nxt;
	logic launch;
	logic tick;

	// A full high-then-low pulse is needed: launch on the falling write
	assign launch = start_r && !start_nxt && en_r;

	always_comb begin
		state_nxt = state_r;
		cyc_nxt = cyc_r;
		busy_nxt = busy_r;
		done = 1'b0;
		unique case (state_r)
			AIC_ST_IDLE: begin
				if (launch) begin
					state_nxt = AIC_ST_SAMPLE;
					cyc_nxt = 4'h0;
					busy_nxt = 1'b1;
				end
			end
			AIC_ST_SAMPLE: begin
				if (tick) begin
					cyc_nxt = cyc_r + 4'h1;
					if (cyc_r == 4'(AIC_SAMPLE_CYC - 1)) begin
						state_nxt = AIC_ST_CONV;
					end
				end
			end
			AIC_ST_CONV: begin
				if (tick) begin
					cyc_nxt = cyc_r + 4'h1;
					if (cyc_r == AIC_TOTAL_CYC - 4'h1) begin
						state_nxt = AIC_ST_IDLE;
						busy_nxt = 1'b0;
						done = 1'b1;
					end
				end
			end
			default: begin
				state_nxt = AIC_ST_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
		// Disabling powers the core down and abandons the conversion
		if (!en_r) begin
			state_nxt = AIC_ST_IDLE;
			busy_nxt = 1'b0;
			done = 1'b0;
		end
	end

	aic_clkdiv u_div (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_run(state_r != AIC_ST_IDLE),
		.i_div_sel(cfg_r.conv_clock_divider_select),
		.o_tick(tick)
	);

	// ======================================================================
	// Read path: data appear the cycle after the read strobe
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				AIC_OFF_CTRL: rdata_nxt = {start_r, busy_r, en_r, fmt_r, chan_r};
				AIC_OFF_CFG: rdata_nxt = cfg_r;
				AIC_OFF_BG: rdata_nxt = {7'h00, bg_en_r};
				AIC_OFF_RES_H: rdata_nxt = fmt_r ? {6'h00, result_r[9:8]}
					: result_r[9:2];
				AIC_OFF_RES_L: rdata_nxt = fmt_r ? result_r[7:0]
					: {result_r[1:0], 6'h00};
				AIC_OFF_IRQ: rdata_nxt = {6'h00, irq_en_r, irq_flag_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// ======================================================================
	// Routing and pin override
	aic_route_s route_w;
	aic_route_s route_nxt;
	logic [AIC_PINS-1:0] ana_nxt;

	aic_route u_route (
		.i_src(cfg_r.input_source_select),
		.i_chan(chan_r),
		.i_ref(cfg_r.reference_select),
		.o_route(route_w)
	);

	always_comb begin
		route_nxt = route_w;
		// Pins only join when an external source is chosen
		route_nxt.ext_pin_on = route_w.sel_ext ? route_w.ext_pin_on : '0;
		ana_nxt = i_pin_analog;
	end

	// ======================================================================
	// Registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			start_r <= 1'b0;
			en_r <= 1'b0;
			fmt_r <= 1'b0;
			chan_r <= 4'h0;
			cfg_r <= AIC_RST_BYTE;
			bg_en_r <= 1'b0;
			irq_en_r <= 1'b0;
			irq_flag_r <= 1'b0;
			result_r <= 10'h000;
			state_r <= AIC_ST_IDLE;
			cyc_r <= 4'h0;
			busy_r <= 1'b0;
			o_rdata <= 8'h00;
			o_route <= '0;
			o_bandgap_enable <= 1'b0;
			o_core_power <= 1'b0;
			o_core_sample <= 1'b0;
			o_core_convert <= 1'b0;
			o_core_clk_tick <= 1'b0;
			o_irq <= 1'b0;
			o_pin_digital_en <= '1;
			o_pin_pullup_allow <= '1;
			o_pin_dir_override <= '0;
		end else begin
			start_r <= start_nxt;
			en_r <= en_nxt;
			fmt_r <= fmt_nxt;
			chan_r <= chan_nxt;
			cfg_r <= cfg_nxt;
			bg_en_r <= bg_en_nxt;
			irq_en_r <= irq_en_nxt;
			irq_flag_r <= irq_flag_nxt;
			result_r <= result_nxt;
			state_r <= state_nxt;
			cyc_r <= cyc_nxt;
			busy_r <= busy_nxt;
			o_rdata <= rdata_nxt;
			o_route <= route_nxt;
			o_bandgap_enable <= bg_en_nxt;
			o_core_power <= en_nxt;
			o_core_sample <= (state_nxt == AIC_ST_SAMPLE);
			o_core_convert <= (state_nxt == AIC_ST_CONV);
			o_core_clk_tick <= tick;
			o_irq <= irq_flag_nxt && irq_en_nxt;
			o_pin_digital_en <= ~ana_nxt;
			o_pin_pullup_allow <= ~ana_nxt;
			o_pin_dir_override <= ana_nxt;
		end
	end

	// ======================================================================
	// Checks
	chk_busy_on_launch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(launch && state_r == AIC_ST_IDLE) |=> busy_r)
		else $error("busy flag not set after start pulse");
	chk_busy_clear_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		done |=> !busy_r && irq_flag_r)
		else $error("busy not cleared or flag not set at completion");
	chk_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_irq |-> $past(irq_en_nxt))
		else $error("interrupt raised while disabled");
	chk_no_start_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!en_r |=> !busy_r)
		else $error("busy set while converter disabled");
	chk_rise_no_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!busy_r && !start_r && start_nxt) |=> !busy_r)
		else $error("conversion started on rising edge of start");
	chk_result_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!en_r |=> $stable(result_r))
		else $error("result changed while disabled");
	chk_bg_read_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_rd && i_addr == AIC_OFF_BG) |=> o_rdata[7:1] == 7'h00)
		else $error("bandgap upper bits not zero");
	chk_right_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_rd && i_addr == AIC_OFF_RES_H && fmt_r) |=> o_rdata[7:2] == 6'h00)
		else $error("right justified high byte upper bits not zero");
	chk_ref_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.reference_select == 2'b10) |=> !o_route.ref_supply || $changed(cfg_r))
		else $error("reference code 10 chose the supply");
	chk_ground_src: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.input_source_select == 3'b100 && $stable(cfg_r))
			|=> o_route.sel_ground && o_route.ext_pin_on == '0)
		else $error("ground source not routed");
	chk_pin_override: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_pin_analog[0] |=> !o_pin_digital_en[0] && !o_pin_pullup_allow[0])
		else $error("analog pin kept digital function or pull-high");
	// ======================================================================
	// Routing, timing and register shadow checks
	chk_ext_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.input_source_select == 3'b110 && $stable(cfg_r)) |=> o_route.sel_ext)
		else $error("external source code did not select the external channel");
	chk_bg_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.input_source_select == 3'b001 && $stable(cfg_r)) |=> o_route.sel_bandgap)
		else $error("bandgap source not routed");
	chk_op0_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.input_source_select == 3'b010 && $stable(cfg_r)) |=> o_route.sel_opamp0)
		else $error("op-amp zero source not routed");
	chk_op1_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.input_source_select == 3'b011 && $stable(cfg_r)) |=> o_route.sel_opamp1)
		else $error("op-amp one source not routed");
	chk_chan_float: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(chan_r > AIC_CH_LAST && $stable(chan_r)) |=> o_route.ext_pin_on == '0)
		else $error("nonexistent channel joined a pin");
	chk_chan_pick: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(aic_is_ext(cfg_r.input_source_select) && chan_r <= AIC_CH_LAST
			&& $stable(chan_r) && $stable(cfg_r)) |=> $onehot(o_route.ext_pin_on))
		else $error("existing channel did not join exactly one pin");
	chk_ref_supply: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.reference_select == 2'b01 && $stable(cfg_r)) |=> o_route.ref_supply)
		else $error("reference code 01 did not choose the supply");
	chk_ref_ext: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(cfg_r.reference_select == 2'b00 && $stable(cfg_r)) |=> !o_route.ref_supply)
		else $error("reference code 00 chose the supply");
	chk_bg_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_bandgap_enable == bg_en_r)
		else $error("bandgap enable output differs from its register");
	chk_busy_state: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		busy_r == (state_r != AIC_ST_IDLE))
		else $error("busy flag disagrees with conversion state");
	chk_conv_after_sample: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_r == AIC_ST_CONV) |-> cyc_r >= 4'(AIC_SAMPLE_CYC))
		else $error("conversion phase entered before sampling finished");
	chk_done_count: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		done |-> cyc_r == AIC_TOTAL_CYC - 4'h1)
		else $error("completion at wrong converter clock count");
	chk_left_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_rd && i_addr == AIC_OFF_RES_L && !fmt_r) |=> o_rdata[5:0] == 6'h00)
		else $error("left justified low byte unused bits not zero");
	chk_irq_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(done && i_wr && i_addr == AIC_OFF_IRQ) |=> irq_flag_r)
		else $error("completion lost against a same-cycle clear");
	chk_pin_dir: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_pin_analog[1] |=> o_pin_dir_override[1] && !o_pin_digital_en[1])
		else $error("analog pin direction not overridden");
	chk_power_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_core_power == en_r)
		else $error("core power differs from converter enable");
	chk_result_on_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$changed(result_r) |-> $past(done))
		else $error("result changed without a completion");
	chk_launch_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_r == AIC_ST_IDLE && state_nxt == AIC_ST_SAMPLE) |-> start_r && !start_nxt)
		else $error("conversion launched without a falling start");

	cov_convert: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) done);
	cov_irq: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_irq);
	cov_abort: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) busy_r && !en_r);
	cov_slow: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		done && cfg_r.conv_clock_divider_select == 3'h7);
endmodule : aic_top

// ---- aic_core_model.sv ----
// Behavioural converter core that answers with a code tied to the routed source
`timescale 1ns/1ps
module aic_core_model
	import aic_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_power,
	input wire logic i_bg_en,
	input wire aic_route_s i_route,
	output logic [9:0] o_result
);
	logic [9:0] junk_r = 10'h000;
	logic [9:0] val;
	// Floating or unpowered input moves every cycle, so a stale latch shows up
	always_ff @(posedge i_clk_sys) begin
		junk_r <= ~junk_r ^ 10'h0A5;
	end
	always_comb begin
		val = junk_r;
		if (i_route.sel_ext && i_route.ext_pin_on != 3'h0) val = {7'h20, i_route.ext_pin_on};
		if (i_route.sel_bandgap && i_bg_en) val = 10'h2AA;
		if (i_route.sel_opamp0) val = 10'h155;
		if (i_route.sel_opamp1) val = 10'h0F0;
		if (i_route.sel_ground) val = 10'h000;
		o_result = i_power ? (i_route.ref_supply ? val ^ 10'h200 : val) : junk_r;
	end
endmodule : aic_core_model

// ---- tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
	import aic_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [2:0] pin_an = 3'h0;
	logic [7:0] rdata;
	logic [9:0] core_res;
	logic pwr, smp, cnv, tick, bg_en, irq;
	logic [2:0] dig_en, pu_ok, dir_ov;
	aic_route_s route;
	logic [7:0] d = 8'h40;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	int n_smp = 0;
	int n_cnv = 0;
	int n_tk = 0;
	aic_top i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_core_result(core_res), .o_core_power(pwr),
		.o_core_sample(smp), .o_core_convert(cnv), .o_core_clk_tick(tick), .o_route(route),
		.o_bandgap_enable(bg_en), .i_pin_analog(pin_an), .o_pin_digital_en(dig_en),
		.o_pin_pullup_allow(pu_ok), .o_pin_dir_override(dir_ov), .o_irq(irq));
	aic_core_model i_core (.i_clk_sys(i_clk_sys), .i_power(pwr), .i_bg_en(bg_en),
		.i_route(route), .o_result(core_res));
	initial forever #2.5 i_clk_sys = ~i_clk_sys;
	// ==========
	// Cycle counter, phase monitor and hang guard
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		n_smp <= n_smp + int'(smp);
		n_cnv <= n_cnv + int'(cnv);
		n_tk <= n_tk + int'(tick);
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	// ==========
	// Access tasks and expectations
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int id);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t check %0d got %h exp %h", $time, id, got, exp);
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : tk
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic rc(input logic [2:0] a, input logic [7:0] exp, input int id);
		rd(a);
		chk(16'(d), 16'(exp), id);
	endtask : rc
	// Pin side first when leaving an external source, so no pin joins an internal one
	// The reference pin is never given its pin function here
	task automatic setup(input logic [2:0] s, input logic [3:0] c, input logic [1:0] r,
			input logic [2:0] dv, input logic [3:0] hi);
		if (s == 3'h0 || s >= 3'h5) begin
			wr(AIC_OFF_CFG, {s, r, dv});
			wr(AIC_OFF_CTRL, {hi, c});
		end else begin
			wr(AIC_OFF_CTRL, {hi, c});
			wr(AIC_OFF_CFG, {s, r, dv});
		end
	endtask : setup
	function automatic aic_route_s exp_route(input logic [2:0] s, input logic [3:0] c,
			input logic [1:0] r);
		aic_route_s e;
		e.sel_ext = (s == 3'h0) || (s >= 3'h5);
		e.sel_bandgap = (s == 3'h1);
		e.sel_opamp0 = (s == 3'h2);
		e.sel_opamp1 = (s == 3'h3);
		e.sel_ground = (s == 3'h4);
		e.ext_pin_on = (e.sel_ext && c <= 4'h2) ? 3'(1 << c) : 3'h0;
		e.ref_supply = (r == 2'h1);
		return e;
	endfunction : exp_route
	function automatic logic [9:0] exp_val(input logic [2:0] s, input logic [3:0] c,
			input logic [1:0] r);
		logic [9:0] e;
		case (s)
			3'h1: e = 10'h2AA;
			3'h2: e = 10'h155;
			3'h3: e = 10'h0F0;
			3'h4: e = 10'h000;
			default: e = 10'h100 | 10'(1 << c);
		endcase
		return (r == 2'h1) ? e ^ 10'h200 : e;
	endfunction : exp_val
	task automatic conv(input logic [2:0] dv);
		logic [2:0] s;
		logic [3:0] c;
		logic [9:0] v;
		int t0;
		s = dv;
		c = (s == 3'h0 || s >= 3'h5) ? 4'(dv % 3) : 4'hF;
		wr(AIC_OFF_IRQ, {6'h00, dv[1], 1'b0});
		setup(s, c, dv[1:0], dv, {3'b101, dv[0]});
		rc(AIC_OFF_CTRL, {3'b101, dv[0], c}, 1);
		wr(AIC_OFF_CTRL, {3'b001, dv[0], c});
		#1;
		n_smp = 0;
		n_cnv = 0;
		n_tk = 0;
		t0 = cyc;
		rc(AIC_OFF_CTRL, {3'b011, dv[0], c}, 2);
		chk(16'(pwr), 16'h1, 11);
		for (int i = 0; i < 1000 && d[6]; i++) rd(AIC_OFF_CTRL);
		chk(16'(cyc - t0 >= (14 << dv) && cyc - t0 <= (14 << dv) + 10), 16'h1, 3);
		chk(16'(n_cnv), 16'(10 << dv), 4);
		chk(16'(n_smp >= (3 << dv) && n_smp <= (4 << dv) + 1), 16'h1, 5);
		chk(16'(n_tk >= 14 && n_tk <= 15), 16'h1, 12);
		v = exp_val(s, c, dv[1:0]);
		rc(AIC_OFF_RES_H, dv[0] ? {6'h00, v[9:8]} : v[9:2], 6);
		rc(AIC_OFF_RES_L, dv[0] ? v[7:0] : {v[1:0], 6'h00}, 7);
		rc(AIC_OFF_IRQ, {6'h00, dv[1], 1'b1}, 8);
		chk(16'(irq), 16'(dv[1]), 9);
		wr(AIC_OFF_IRQ, {6'h00, dv[1], 1'b1});
		tk(2);
		chk(16'(irq), 16'h0, 10);
	endtask : conv
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	// ==========
	// Main sequence
	initial begin
		logic [3:0] c;
		repeat (12) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) rc(3'(a), 8'h00, 20 + a);
		wr(3'h6, 8'hFF);
		rc(3'h6, 8'h00, 30);
		wr(AIC_OFF_RES_H, 8'hFF);
		rc(AIC_OFF_RES_H, 8'h00, 31);
		wr(AIC_OFF_CTRL, 8'h40);
		rc(AIC_OFF_CTRL, 8'h00, 32);
		wr(AIC_OFF_BG, 8'hFF);
		rc(AIC_OFF_BG, 8'h01, 33);
		chk(16'(bg_en), 16'h1, 34);
		wr(AIC_OFF_BG, 8'h00);
		tk(2);
		chk(16'(bg_en), 16'h0, 35);
		for (int k = 0; k < 32; k++) begin
			c = (k % 8 == 0 || k % 8 >= 5) ? 4'(k / 8) : 4'hF;
			setup(3'(k), c, 2'(k / 8), 3'h0, 4'h0);
			tk(3);
			chk(16'(route), 16'(exp_route(3'(k), c, 2'(k / 8))), 40);
		end
		for (int p = 0; p < 8; p++) begin
			@(posedge i_clk_sys);
			pin_an <= 3'(p);
			tk(3);
			chk({dig_en, pu_ok, dir_ov}, {~3'(p), ~3'(p), 3'(p)}, 50);
		end
		wr(AIC_OFF_BG, 8'h01);
		for (int dv = 0; dv < 8; dv++) conv(3'(dv));
		wr(AIC_OFF_CTRL, 8'h91);
		wr(AIC_OFF_CTRL, 8'h11);
		tk(30);
		rc(AIC_OFF_CTRL, 8'h11, 60);
		chk({pwr, smp}, 16'h0, 61);
		rc(AIC_OFF_RES_L, 8'h02, 62);
		setup(3'h4, 4'hF, 2'h0, 3'h0, 4'hB);
		wr(AIC_OFF_CTRL, 8'h3F);
		tk(3);
		wr(AIC_OFF_CTRL, 8'h1F);
		tk(30);
		rc(AIC_OFF_CTRL, 8'h1F, 63);
		rc(AIC_OFF_IRQ, 8'h02, 64);
		rc(AIC_OFF_RES_L, 8'h02, 65);
		final_report();
	end
endmodule : tb
